// ### rtl/quad_dac_register_latch_control.sv
// Serial input, double-buffered register control of a four-channel 12-bit converter.
//
// Overview of operation
// (R1) Update pin low: all four DAC registers follow inputs; high: they hold.
// (R2) Load pin low: addressed input register follows shifted code; high: it holds.
// (R3) Reset pin low forces all input and DAC registers to reset code.
// (R4) Reset code is 000 with select low, 800 with select high.
// (R5) Serial word is 16 bits: address, two unused, 12-bit code MSB first.
// (R6) Address 00/01/10/11 selects input register A/B/C/D.
// (R7) Shift on serial clock rise only with select low, load and reset high.
// (R8) After reset release, latched registers keep the reset code until loaded.
// (R9) Load and update low together pass a new code straight to DAC register.
`timescale 1ns/1ps

module quad_dac_register_latch_control
	import quad_dac_latch_pkg::*;
(
	input  wire logic  clock,
	input  wire logic  resetn,
	input  wire logic  serial_clock,
	input  wire logic  serial_data_in,
	input  wire logic  chip_select_n,
	input  wire logic  input_load_n,
	input  wire logic  update_all_n,
	input  wire logic  device_reset_n,
	input  wire logic  reset_code_select,
	output code_t      dac_code_a,
	output code_t      dac_code_b,
	output code_t      dac_code_c,
	output code_t      dac_code_d
);

	logic [PIN_COUNT-1:0] pin_meta;
	logic [PIN_COUNT-1:0] pin_sync;
	logic                 sclk_prev;
	logic [WORD_BITS-1:0] shift_word;
	code_t                input_a;
	code_t                input_b;
	code_t                input_c;
	code_t                input_d;

	logic                 sclk_rise;
	logic                 cs_active;
	logic                 shift_enable;
	logic                 load_active;
	logic                 update_active;
	logic                 reset_active;
	logic [1:0]           word_addr;
	code_t                word_code;
	code_t                reset_code;

	// Reset code chosen by the synchronised select pin.
	function automatic code_t pick_reset_code(input logic select_high);
		pick_reset_code = select_high ? MID_SCALE_CODE : ZERO_SCALE_CODE; // R4
	endfunction : pick_reset_code

	// True when the address field of the shifted word names this channel.
	function automatic logic selects_channel(
		input logic [1:0] addr,
		input logic [1:0] channel
	);
		selects_channel = (addr == channel); // R6
	endfunction : selects_channel

	// Next value of one input register. Reset outranks loading, and a register
	// that is not loaded keeps whatever it holds, the reset code included.
	function automatic code_t next_input_code(
		input code_t held,
		input code_t shifted,
		input logic  do_reset,
		input logic  do_load,
		input code_t reset_value
	);
		if (do_reset) begin
			next_input_code = reset_value; // R3
		end else if (do_load) begin
			next_input_code = shifted; // R2
		end else begin
			next_input_code = held; // R8
		end
	endfunction : next_input_code

	// Next value of one DAC register, with the same priorities as above.
	function automatic code_t next_dac_code(
		input code_t held,
		input code_t staged,
		input logic  do_reset,
		input logic  do_update,
		input code_t reset_value
	);
		if (do_reset) begin
			next_dac_code = reset_value; // R3
		end else if (do_update) begin
			next_dac_code = staged; // R1 R9
		end else begin
			next_dac_code = held; // R8
		end
	endfunction : next_dac_code

	// Every pin comes from the host's domain, so all pass two flip-flops together.
	// Keeping clock and data in one vector keeps their delay equal, so the data
	// seen at a detected clock edge is the data that stood at that edge.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pin_meta <= PIN_IDLE;
			pin_sync <= PIN_IDLE;
		end else begin
			pin_meta <= {reset_code_select, device_reset_n, update_all_n, input_load_n,
				chip_select_n, serial_data_in, serial_clock};
			pin_sync <= pin_meta;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sclk_prev <= 1'b0;
		end else begin
			sclk_prev <= pin_sync[PIN_SCLK];
		end
	end

	assign sclk_rise     = pin_sync[PIN_SCLK] && !sclk_prev;
	assign cs_active     = !pin_sync[PIN_CS_N];
	assign load_active   = !pin_sync[PIN_LOAD_N];
	assign update_active = !pin_sync[PIN_UPDATE_N];
	assign reset_active  = !pin_sync[PIN_RESET_N];
	assign reset_code    = pick_reset_code(pin_sync[PIN_RESET_SEL]);

	// Shifting is blocked while loading so the addressed word cannot change
	// under a transparent input register.
	assign shift_enable  = sclk_rise && cs_active && !load_active && !reset_active; // R7

	// Address and code fields of the last sixteen bits shifted in. Extra rises
	// simply push the oldest bits out, so only the last sixteen count.
	assign word_addr     = shift_word[ADDR_MSB:ADDR_LSB]; // R5
	assign word_code     = shift_word[CODE_MSB:CODE_LSB]; // R5

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			shift_word <= '0;
		end else if (shift_enable) begin // R7
			shift_word <= {shift_word[WORD_BITS-2:0], pin_sync[PIN_SDATA]}; // R5
		end
	end

	// One input register per channel. Only the addressed one follows the shift
	// word while loading; the others hold.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			input_a <= ZERO_SCALE_CODE;
		end else begin
			input_a <= next_input_code(input_a, word_code, reset_active,
				load_active && selects_channel(word_addr, CHANNEL_A), reset_code); // R2 R6
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			input_b <= ZERO_SCALE_CODE;
		end else begin
			input_b <= next_input_code(input_b, word_code, reset_active,
				load_active && selects_channel(word_addr, CHANNEL_B), reset_code); // R2 R6
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			input_c <= ZERO_SCALE_CODE;
		end else begin
			input_c <= next_input_code(input_c, word_code, reset_active,
				load_active && selects_channel(word_addr, CHANNEL_C), reset_code); // R2 R6
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			input_d <= ZERO_SCALE_CODE;
		end else begin
			input_d <= next_input_code(input_d, word_code, reset_active,
				load_active && selects_channel(word_addr, CHANNEL_D), reset_code); // R2 R6
		end
	end

	// The system reset may only load constants, so it always clears to zero
	// scale; the selectable reset code comes only through the device reset pin.
	// The DAC registers are the outputs themselves and follow the input registers
	// one clock behind, so with both controls low a fresh code needs one more clock.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			dac_code_a <= ZERO_SCALE_CODE;
		end else begin
			dac_code_a <= next_dac_code(dac_code_a, input_a, reset_active, update_active,
				reset_code); // R1
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			dac_code_b <= ZERO_SCALE_CODE;
		end else begin
			dac_code_b <= next_dac_code(dac_code_b, input_b, reset_active, update_active,
				reset_code); // R1
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			dac_code_c <= ZERO_SCALE_CODE;
		end else begin
			dac_code_c <= next_dac_code(dac_code_c, input_c, reset_active, update_active,
				reset_code); // R1
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			dac_code_d <= ZERO_SCALE_CODE;
		end else begin
			dac_code_d <= next_dac_code(dac_code_d, input_d, reset_active, update_active,
				reset_code); // R1
		end
	end

endmodule : quad_dac_register_latch_control

// ### rtl/quad_dac_latch_pkg.sv
// Constants shared by the quad converter latch control.
package quad_dac_latch_pkg;

	localparam int unsigned WORD_BITS = 16;
	localparam int unsigned CODE_BITS = 12;
	localparam int unsigned CHANNELS  = 4;

	// Serial word layout, counted from the last bit shifted in.
	localparam int unsigned ADDR_MSB = 15;
	localparam int unsigned ADDR_LSB = 14;
	localparam int unsigned CODE_MSB = 11;
	localparam int unsigned CODE_LSB = 0;

	localparam logic [CODE_BITS-1:0] ZERO_SCALE_CODE = 12'h000;
	localparam logic [CODE_BITS-1:0] MID_SCALE_CODE  = 12'h800;

	localparam logic [1:0] CHANNEL_A = 2'h0;
	localparam logic [1:0] CHANNEL_B = 2'h1;
	localparam logic [1:0] CHANNEL_C = 2'h2;
	localparam logic [1:0] CHANNEL_D = 2'h3;

	// Bit positions of the pin inputs inside the synchroniser vectors.
	localparam int unsigned PIN_COUNT      = 7;
	localparam int unsigned PIN_SCLK       = 0;
	localparam int unsigned PIN_SDATA      = 1;
	localparam int unsigned PIN_CS_N       = 2;
	localparam int unsigned PIN_LOAD_N     = 3;
	localparam int unsigned PIN_UPDATE_N   = 4;
	localparam int unsigned PIN_RESET_N    = 5;
	localparam int unsigned PIN_RESET_SEL  = 6;

	localparam logic [PIN_COUNT-1:0] PIN_IDLE = 7'h3c;

	typedef logic [CODE_BITS-1:0] code_t;

endpackage : quad_dac_latch_pkg

// ### dv/quad_dac_checker.sv
// Output checks of the latch control.
`timescale 1ns/1ps
module quad_dac_checker import quad_dac_latch_pkg::*; (
	input logic  clock,
	input logic  resetn,
	input logic  input_load_n,
	input logic  update_all_n,
	input logic  device_reset_n,
	input logic  reset_code_select,
	input code_t dac_code_a,
	input code_t dac_code_b,
	input code_t dac_code_c,
	input code_t dac_code_d
);
	wire logic [47:0] o = {dac_code_a, dac_code_b, dac_code_c, dac_code_d};
	logic      [4:0]  u, r, s;
	// Bit 2 is the pin three edges back: two sync flops plus the write.
	always_ff @(posedge clock) begin
		u <= {u[3:0], update_all_n};
		r <= {r[3:0], device_reset_n};
		s <= {s[3:0], reset_code_select};
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	AST_HOLD: assert property (u[2] && r[2] |-> $stable(o[47:24])) else $error("hold");
	AST_UPD_ONLY: assert property (!$stable(o[23:0]) |-> !u[2] || !r[2]) else $error("upd");
	AST_LOAD_LATCH: assert property (!u[2] && !u[3] && &r[3:2] && $past(input_load_n, 4)
		|-> $stable(o)) else $error("load");
	AST_RST_ZERO: assert property (!r[2] && !s[2] |-> o == 48'h0) else $error("zero");
	AST_RST_MID: assert property (!r[2] && s[2] |-> o == {4{MID_SCALE_CODE}}) else $error("mid");
	AST_RST_KEEP: assert property (r[2] && !r[3] && u[2] |-> o == {4{s[3], 11'h0}})
		else $error("keep");
	AST_RST_FALL: assert property ($fell(device_reset_n) |-> ##3 o[11:0] == {s[2], 11'h0})
		else $error("fall");
	AST_SYS_RST: assert property (disable iff (1'b0) !resetn |=> o == 48'h0) else $error("sys");
endmodule : quad_dac_checker
bind quad_dac_register_latch_control quad_dac_checker i_chk (.*);

// ### dv/host_model.sv
// Host controller model: serial word, load, update and reset pins.
`timescale 1ns/1ps
module host_model (
	input  logic clock,
	output logic serial_clock = 0,
	output logic serial_data_in = 1,
	output logic chip_select_n = 1,
	output logic input_load_n = 1,
	output logic update_all_n = 1,
	output logic device_reset_n = 1,
	output logic reset_code_select = 0
);
	task automatic send(input logic [1:0] a, input logic [11:0] c, input logic cs_n);
		logic [15:0] w;
		w = {a, 2'h0, c};
		chip_select_n <= cs_n;
		for (int i = 15; i >= 0; i--) begin
			serial_data_in <= w[i];
			repeat (8) @(posedge clock);
			serial_clock <= 1'b1;
			repeat (8) @(posedge clock);
			serial_clock <= 1'b0;
		end
		chip_select_n <= 1'b1;
		serial_data_in <= ~w[0];
		input_load_n <= 1'b0;
		repeat (6) @(posedge clock);
		input_load_n <= 1'b1;
	endtask : send
	task automatic upd();
		update_all_n <= 1'b0;
		repeat (6) @(posedge clock);
		update_all_n <= 1'b1;
		repeat (6) @(posedge clock);
		$display("step done");
	endtask : upd
	task automatic rst(input logic sel);
		reset_code_select <= sel;
		repeat (4) @(posedge clock);
		device_reset_n <= 1'b0;
		repeat (9) @(posedge clock);
		device_reset_n <= 1'b1;
		repeat (8) @(posedge clock);
	endtask : rst
endmodule : host_model

// ### dv/tb_top.sv
// Self-checking bench of the latch control.
`timescale 1ns/1ps
module tb_top import quad_dac_latch_pkg::*;;
	logic        clock = 0, resetn = 0;
	wire         serial_clock, serial_data_in, chip_select_n, input_load_n;
	wire         update_all_n, device_reset_n, reset_code_select;
	code_t       dac_code_a, dac_code_b, dac_code_c, dac_code_d, v[4];
	wire  [47:0] o = {dac_code_a, dac_code_b, dac_code_c, dac_code_d};
	logic [47:0] q[$], last = 0;
	int          n_errors = 0, cmp_count = 0, cyc = 0, seed = 23;
	host_model i_host (.*);
	quad_dac_register_latch_control i_dut (.*);
	initial forever #4 clock = ~clock;
	task automatic check(input logic [47:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t %h %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : stop_test
	always @(posedge clock) begin
		if (cyc++ == 5000) begin
			n_errors++;
			stop_test();
		end
		if (resetn && o !== last) begin
			last <= o;
			check(o, q.size() ? q.pop_front() : ~o);
		end
	end
	initial begin
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			v[i] = 12'($random(seed));
			i_host.send(2'(i), v[i], 1'b0);
		end
		q.push_back({v[0], v[1], v[2], v[3]});
		i_host.upd();
		i_host.send(2'h1, ~v[1], 1'b1);
		i_host.upd();
		for (int k = 1; k >= 0; k--) begin
			q.push_back({4{k[0], 11'h0}});
			i_host.rst(k[0]);
			i_host.upd();
		end
		q.push_back({24'h0, v[3] | 12'h1, 12'h0});
		fork
			begin
				repeat (WORD_BITS * 16) @(posedge clock);
				i_host.upd();
			end
			i_host.send(2'h2, v[3] | 12'h1, 1'b0);
		join
		check(48'(q.size()), 48'h0);
		i_host.upd();
		stop_test();
	end
endmodule : tb_top
